/* File: pmf_pkg.sv */
// Constants, types and carriers shared by the pixel mode formatter
package pmf_pkg;

    // ------------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------------
    localparam int PIX_W      = 8;
    localparam int OVL_W      = 4;
    localparam int COMP15_W   = 5;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_LVL_W = 5;

    // Input is refused once this many words sit in the FIFO
    localparam logic [FIFO_LVL_W-1:0] READY_LIMIT = 5'h0c;

    // ------------------------------------------------------------------
    // Command register fields and reset values
    // ------------------------------------------------------------------
    localparam int CMD_BUS_HI    = 7;
    localparam int CMD_BUS_LO    = 6;
    localparam int CMD_SETUP_BIT = 5;
    localparam logic [PIX_W-1:0] MASK_RESET = 8'hff;
    localparam logic [PIX_W-1:0] CMD_RESET  = 8'h00;

    // Host register select
    localparam logic HOST_SEL_MASK = 1'b0;
    localparam logic HOST_SEL_CMD  = 1'b1;

    // ------------------------------------------------------------------
    // Pixel field layout
    // ------------------------------------------------------------------
    localparam logic [2:0] PAL15_TOP = 3'h7;   // Upper 32 palette entries
    localparam logic [PIX_W-1:0] BLANK_CODE = 8'h00;
    localparam logic [PIX_W-1:0] ZERO_CODE  = 8'h00;
    localparam logic [OVL_W-1:0] OVL_NONE   = 4'h0;

    // Mode pin codes
    localparam logic [1:0] PINS_PAL24 = 2'h0;
    localparam logic [1:0] PINS_BYP24 = 2'h1;
    localparam logic [1:0] PINS_INDEX = 2'h2;
    localparam logic [1:0] PINS_BYP8  = 2'h3;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_RED   = 2'h0,
        BUS_GREEN = 2'h1,
        BUS_BLUE  = 2'h2,
        BUS_BOTH  = 2'h3
    } pmf_bus_t;

    typedef enum logic [2:0] {
        MODE_PAL24   = 3'h0,
        MODE_BYP24   = 3'h1,
        MODE_PSEUDO8 = 3'h2,
        MODE_PAL15   = 3'h3,
        MODE_BYP8    = 3'h4,
        MODE_BYP15   = 3'h5,
        MODE_RSVD    = 3'h6
    } pmf_mode_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [OVL_W-1:0] ovl;
        logic [1:0]       pins;
        logic [PIX_W-1:0] red;
        logic [PIX_W-1:0] green;
        logic [PIX_W-1:0] blue;
        logic             sync_n;
        logic             blank_n;
    } pmf_pixel_t;

    typedef struct packed {
        logic [PIX_W-1:0] red;
        logic [PIX_W-1:0] green;
        logic [PIX_W-1:0] blue;
        logic             sync_n;
        logic             blank_n;
    } pmf_dac_t;

endpackage

/* File: pmf_fifo.sv */
// Flop based FIFO with valid/ready on both sides
`timescale 1ns/10ps
module pmf_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     reset,
    // Fill side
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    // Drain side
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data,
    // Occupancy
    output logic [$clog2(DEPTH):0]        level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg  [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW-1:0]    rd_ptr_next;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             push;
    logic             pop;

    // Honest flags from the word count
    assign in_ready  = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign level     = cnt_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next pointers, count and storage
    always_comb
    begin
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        cnt_next    = cnt_reg;
        if (push)
        begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next          = wr_ptr_reg + 1'b1;
        end
        if (pop)
            rd_ptr_next = rd_ptr_reg + 1'b1;
        if (push && !pop)
            cnt_next = cnt_reg + 1'b1;
        else if (pop && !push)
            cnt_next = cnt_reg - 1'b1;
    end

    // Register stage
    always_ff @(posedge sys_clk)
    begin
        mem_reg <= mem_next;
        if (reset)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg    <= cnt_next;
        end
    end

endmodule // pmf_fifo

/* File: pmf_formatter.sv */
// Pixel mode formatter: mode decode, mask, palette, overlay, blanking
`timescale 1ns/10ps
module pmf_formatter (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    // Pixel input stream
    input  wire logic                      pixel_valid,
    output logic                           pixel_ready,
    input  wire logic [pmf_pkg::PIX_W-1:0] red_pixel_bus,
    input  wire logic [pmf_pkg::PIX_W-1:0] green_pixel_bus,
    input  wire logic [pmf_pkg::PIX_W-1:0] blue_pixel_bus,
    input  wire logic [pmf_pkg::OVL_W-1:0] overlay_select,
    input  wire logic                      pixel_mode_pin_hi,
    input  wire logic                      pixel_mode_pin_lo,
    input  wire logic                      sync_n,
    input  wire logic                      blank_n,
    // Host register port
    input  wire logic [pmf_pkg::PIX_W-1:0] host_data_bus,
    input  wire logic                      host_sel,
    input  wire logic                      host_wr,
    input  wire logic                      host_rd,
    output logic [pmf_pkg::PIX_W-1:0]      host_read_data,
    output logic                           host_read_valid,
    // Palette and overlay lookup, one cycle read latency
    output logic [pmf_pkg::PIX_W-1:0]      pal_addr_red,
    output logic [pmf_pkg::PIX_W-1:0]      pal_addr_green,
    output logic [pmf_pkg::PIX_W-1:0]      pal_addr_blue,
    input  wire pmf_pkg::pmf_dac_t         pal_data,
    output logic [pmf_pkg::OVL_W-1:0]      ovl_addr,
    input  wire pmf_pkg::pmf_dac_t         ovl_data,
    // Converter output stream
    output logic                           dac_valid,
    input  wire logic                      dac_ready,
    output logic [pmf_pkg::PIX_W-1:0]      dac_red,
    output logic [pmf_pkg::PIX_W-1:0]      dac_green,
    output logic [pmf_pkg::PIX_W-1:0]      dac_blue,
    output logic                           dac_sync_n,
    output logic                           dac_blank_n,
    output logic                           dac_setup_en
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Mode from pins and bus select
    function automatic pmf_pkg::pmf_mode_t decode_mode(
        input logic [1:0] pins,
        input logic [1:0] bsel
    );
        decode_mode = pmf_pkg::MODE_RSVD;
        unique case (pins)
            pmf_pkg::PINS_PAL24:
                if (bsel != pmf_pkg::BUS_BOTH)
                    decode_mode = pmf_pkg::MODE_PAL24;
            pmf_pkg::PINS_BYP24:
                if (bsel != pmf_pkg::BUS_BOTH)
                    decode_mode = pmf_pkg::MODE_BYP24;
            pmf_pkg::PINS_INDEX:
                decode_mode = (bsel == pmf_pkg::BUS_BOTH) ?
                    pmf_pkg::MODE_PAL15 : pmf_pkg::MODE_PSEUDO8;
            pmf_pkg::PINS_BYP8:
                decode_mode = (bsel == pmf_pkg::BUS_BOTH) ?
                    pmf_pkg::MODE_BYP15 : pmf_pkg::MODE_BYP8;
        endcase
    endfunction

    // Byte from the bus that the select bits name
    function automatic logic [pmf_pkg::PIX_W-1:0] pick_bus(
        input pmf_pkg::pmf_pixel_t p,
        input logic [1:0]          bsel
    );
        unique case (bsel)
            pmf_pkg::BUS_GREEN: pick_bus = p.green;
            pmf_pkg::BUS_BLUE:  pick_bus = p.blue;
            default:            pick_bus = p.red;
        endcase
    endfunction

    // 15-bit pixel split into its three five-bit components
    function automatic logic [3*pmf_pkg::COMP15_W-1:0] split15(
        input pmf_pkg::pmf_pixel_t p
    );
        split15 = {p.red[6:2], p.red[1:0], p.green[7:5], p.green[4:0]};
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int CW = pmf_pkg::COMP15_W;

    pmf_pkg::pmf_pixel_t  s1_pix_reg,  s1_pix_next;
    pmf_pkg::pmf_pixel_t  s2_pix_reg,  s2_pix_next;
    pmf_pkg::pmf_pixel_t  s3_pix_reg,  s3_pix_next;
    pmf_pkg::pmf_mode_t   s2_mode_reg, s2_mode_next;
    pmf_pkg::pmf_mode_t   s3_mode_reg, s3_mode_next;
    logic                 s1_vld_reg,  s1_vld_next;
    logic                 s2_vld_reg,  s2_vld_next;
    logic                 s3_vld_reg,  s3_vld_next;
    logic [1:0]           s2_bsel_reg, s2_bsel_next;
    logic [1:0]           s3_bsel_reg, s3_bsel_next;
    logic                 ready_reg,   ready_next;

    logic [pmf_pkg::PIX_W-1:0] mask_red_reg,   mask_red_next;
    logic [pmf_pkg::PIX_W-1:0] mask_green_reg, mask_green_next;
    logic [pmf_pkg::PIX_W-1:0] mask_blue_reg,  mask_blue_next;
    logic [pmf_pkg::PIX_W-1:0] cmd_reg,        cmd_next;
    logic [pmf_pkg::PIX_W-1:0] rd_data_reg,    rd_data_next;
    logic                      rd_vld_reg,     rd_vld_next;

    logic [pmf_pkg::PIX_W-1:0] par_reg, par_next;
    logic [pmf_pkg::PIX_W-1:0] pag_reg, pag_next;
    logic [pmf_pkg::PIX_W-1:0] pab_reg, pab_next;
    logic [pmf_pkg::OVL_W-1:0] oa_reg,  oa_next;

    pmf_pkg::pmf_dac_t    out_reg, out_next;
    logic                 out_vld_reg, out_vld_next;
    logic                 setup_reg, setup_next;

    pmf_pkg::pmf_dac_t    word;
    pmf_pkg::pmf_dac_t    fifo_q;
    logic                 fifo_in_ready;
    logic                 fifo_out_valid;
    logic                 fifo_pop;
    logic [pmf_pkg::FIFO_LVL_W-1:0] fifo_level;
    logic [1:0]           bsel;
    logic [pmf_pkg::PIX_W-1:0] sel_byte;
    logic [3*CW-1:0]      c15;

    assign bsel = {cmd_reg[pmf_pkg::CMD_BUS_HI], cmd_reg[pmf_pkg::CMD_BUS_LO]};

    // ------------------------------------------------------------------
    // Host registers: mask copies and command register
    // ------------------------------------------------------------------

    // Host writes and reads, independent of the pixel pipe
    always_comb
    begin
        mask_red_next   = mask_red_reg;
        mask_green_next = mask_green_reg;
        mask_blue_next  = mask_blue_reg;
        cmd_next        = cmd_reg;
        rd_data_next    = rd_data_reg;
        rd_vld_next     = host_rd;
        if (host_wr && host_sel == pmf_pkg::HOST_SEL_MASK)
        begin
            mask_red_next   = host_data_bus;
            mask_green_next = host_data_bus;
            mask_blue_next  = host_data_bus;
        end
        if (host_wr && host_sel == pmf_pkg::HOST_SEL_CMD)
            cmd_next = host_data_bus;
        if (host_rd)
            rd_data_next = (host_sel == pmf_pkg::HOST_SEL_CMD) ?
                cmd_reg : mask_red_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            mask_red_reg   <= pmf_pkg::MASK_RESET;
            mask_green_reg <= pmf_pkg::MASK_RESET;
            mask_blue_reg  <= pmf_pkg::MASK_RESET;
            cmd_reg        <= pmf_pkg::CMD_RESET;
            rd_data_reg    <= pmf_pkg::ZERO_CODE;
            rd_vld_reg     <= 1'b0;
        end
        else
        begin
            mask_red_reg   <= mask_red_next;
            mask_green_reg <= mask_green_next;
            mask_blue_reg  <= mask_blue_next;
            cmd_reg        <= cmd_next;
            rd_data_reg    <= rd_data_next;
            rd_vld_reg     <= rd_vld_next;
        end
    end

    // ------------------------------------------------------------------
    // Pixel pipeline: capture, address, lookup
    // ------------------------------------------------------------------

    // Stage advance; every path takes the same three stages
    always_comb
    begin
        s1_vld_next = pixel_valid && ready_reg;
        s1_pix_next = s1_pix_reg;
        if (s1_vld_next)
            s1_pix_next = '{ovl: overlay_select,
                            pins: {pixel_mode_pin_hi,
                                   pixel_mode_pin_lo},
                            red: red_pixel_bus,
                            green: green_pixel_bus,
                            blue: blue_pixel_bus,
                            sync_n: sync_n,
                            blank_n: blank_n};
        s2_vld_next  = s1_vld_reg;
        s2_pix_next  = s1_pix_reg;
        s2_bsel_next = bsel;
        s2_mode_next = decode_mode(s1_pix_reg.pins, bsel);
        s3_vld_next  = s2_vld_reg;
        s3_pix_next  = s2_pix_reg;
        s3_mode_next = s2_mode_reg;
        s3_bsel_next = s2_bsel_reg;
        ready_next   = (fifo_level < pmf_pkg::READY_LIMIT);
    end

    // Palette and overlay addresses for the captured pixel
    always_comb
    begin
        c15      = split15(s1_pix_reg);
        sel_byte = pick_bus(s1_pix_reg, bsel);
        par_next = pmf_pkg::ZERO_CODE;
        pag_next = pmf_pkg::ZERO_CODE;
        pab_next = pmf_pkg::ZERO_CODE;
        oa_next  = s1_pix_reg.ovl;
        unique case (s2_mode_next)
            pmf_pkg::MODE_PAL24:
            begin
                par_next = s1_pix_reg.red   & mask_red_reg;
                pag_next = s1_pix_reg.green & mask_green_reg;
                pab_next = s1_pix_reg.blue  & mask_blue_reg;
            end
            pmf_pkg::MODE_PSEUDO8:
            begin
                unique case (bsel)
                    pmf_pkg::BUS_GREEN: par_next = sel_byte & mask_green_reg;
                    pmf_pkg::BUS_BLUE:  par_next = sel_byte & mask_blue_reg;
                    default:            par_next = sel_byte & mask_red_reg;
                endcase
                pag_next = par_next;
                pab_next = par_next;
            end
            pmf_pkg::MODE_PAL15:
            begin
                par_next = {pmf_pkg::PAL15_TOP, c15[3*CW-1:2*CW]};
                pag_next = {pmf_pkg::PAL15_TOP, c15[2*CW-1:CW]};
                pab_next = {pmf_pkg::PAL15_TOP, c15[CW-1:0]};
            end
            default:
            begin
                par_next = pmf_pkg::ZERO_CODE;
            end
        endcase
    end

    // Final color: mode first, then overlay, then blanking
    always_comb
    begin
        word  = '0;
        word.sync_n  = s3_pix_reg.sync_n;
        word.blank_n = s3_pix_reg.blank_n;
        unique case (s3_mode_reg)
            pmf_pkg::MODE_PAL24, pmf_pkg::MODE_PSEUDO8,
            pmf_pkg::MODE_PAL15:
            begin
                word.red   = pal_data.red;
                word.green = pal_data.green;
                word.blue  = pal_data.blue;
            end
            pmf_pkg::MODE_BYP24:
            begin
                word.red   = s3_pix_reg.red;
                word.green = s3_pix_reg.green;
                word.blue  = s3_pix_reg.blue;
            end
            pmf_pkg::MODE_BYP8:
            begin
                word.red   = pick_bus(s3_pix_reg, s3_bsel_reg);
                word.green = {word.red[4:2], 5'h00};
                word.blue  = {word.red[1:0], 6'h00};
                word.red   = {word.red[7:5], 5'h00};
            end
            pmf_pkg::MODE_BYP15:
            begin
                word.red   = {s3_pix_reg.red[6:2], 3'h0};
                word.green = {s3_pix_reg.red[1:0],
                              s3_pix_reg.green[7:5], 3'h0};
                word.blue  = {s3_pix_reg.green[4:0], 3'h0};
            end
            default:
            begin
                word.red = pmf_pkg::ZERO_CODE;
            end
        endcase
        if (s3_pix_reg.ovl != pmf_pkg::OVL_NONE)
        begin
            word.red   = ovl_data.red;
            word.green = ovl_data.green;
            word.blue  = ovl_data.blue;
        end
        if (!s3_pix_reg.blank_n)
        begin
            word.red   = pmf_pkg::BLANK_CODE;
            word.green = pmf_pkg::BLANK_CODE;
            word.blue  = pmf_pkg::BLANK_CODE;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s1_vld_reg <= 1'b0;
            s2_vld_reg <= 1'b0;
            s3_vld_reg <= 1'b0;
            ready_reg  <= 1'b0;
        end
        else
        begin
            s1_vld_reg <= s1_vld_next;
            s2_vld_reg <= s2_vld_next;
            s3_vld_reg <= s3_vld_next;
            ready_reg  <= ready_next;
        end
        s1_pix_reg  <= s1_pix_next;
        s2_pix_reg  <= s2_pix_next;
        s3_pix_reg  <= s3_pix_next;
        s2_mode_reg <= s2_mode_next;
        s3_mode_reg <= s3_mode_next;
        s2_bsel_reg <= s2_bsel_next;
        s3_bsel_reg <= s3_bsel_next;
        par_reg     <= par_next;
        pag_reg     <= pag_next;
        pab_reg     <= pab_next;
        oa_reg      <= oa_next;
    end

    // ------------------------------------------------------------------
    // Output FIFO and converter register
    // ------------------------------------------------------------------
    pmf_fifo #(
        .WIDTH ($bits(pmf_pkg::pmf_dac_t)),
        .DEPTH (pmf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_valid  (s3_vld_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_q),
        .level     (fifo_level)
    );

    assign fifo_pop = fifo_out_valid && (!out_vld_reg || dac_ready);

    // Converter word register with sync and pedestal flags
    always_comb
    begin
        out_next     = out_reg;
        out_vld_next = out_vld_reg && !dac_ready;
        setup_next   = cmd_reg[pmf_pkg::CMD_SETUP_BIT];
        if (fifo_pop)
        begin
            out_next     = fifo_q;
            out_vld_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            out_reg     <= '{default: '0, sync_n: 1'b1, blank_n: 1'b0};
            out_vld_reg <= 1'b0;
            setup_reg   <= 1'b0;
        end
        else
        begin
            out_reg     <= out_next;
            out_vld_reg <= out_vld_next;
            setup_reg   <= setup_next;
        end
    end

    // Port drive
    assign pixel_ready     = ready_reg;
    assign host_read_data  = rd_data_reg;
    assign host_read_valid = rd_vld_reg;
    assign pal_addr_red    = par_reg;
    assign pal_addr_green  = pag_reg;
    assign pal_addr_blue   = pab_reg;
    assign ovl_addr        = oa_reg;
    assign dac_valid       = out_vld_reg;
    assign dac_red         = out_reg.red;
    assign dac_green       = out_reg.green;
    assign dac_blue        = out_reg.blue;
    assign dac_sync_n      = out_reg.sync_n;
    assign dac_blank_n     = out_reg.blank_n;
    assign dac_setup_en    = setup_reg;

endmodule // pmf_formatter

/* File: pmf_formatter_checker.sv */
// Port assertions for the pixel mode formatter
`timescale 1ns/10ps
module pmf_formatter_checker (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       reset,
    // Pixel and host side
    input wire logic       pixel_valid,
    input wire logic       pixel_ready,
    input wire logic       host_sel,
    input wire logic       host_wr,
    input wire logic       host_rd,
    input wire logic [7:0] host_data_bus,
    input wire logic [7:0] host_read_data,
    input wire logic       host_read_valid,
    // Converter side
    input wire logic       dac_valid,
    input wire logic       dac_ready,
    input wire logic [7:0] dac_red,
    input wire logic [7:0] dac_green,
    input wire logic [7:0] dac_blue,
    input wire logic       dac_blank_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ----
    // Properties
    // ----
    AST_RDV: assert property (host_rd |=> host_read_valid)
        else $error("read valid missing");
    AST_RDV_ONLY: assert property (!host_rd |=> !host_read_valid)
        else $error("read valid without read");
    AST_MASK_RD: assert property (host_wr && !host_sel ##1
        host_rd && !host_wr && !host_sel
        |=> host_read_data == $past(host_data_bus, 2))
        else $error("mask read differs from write");
    AST_HOLD: assert property (dac_valid && !dac_ready |=>
        dac_valid && $stable({dac_red, dac_green, dac_blue}))
        else $error("converter word changed while stalled");
    AST_BLANK: assert property (dac_valid && !dac_blank_n |->
        {dac_red, dac_green, dac_blue} == 24'h000000)
        else $error("blanked word not zero");
    AST_LAT: assert property (pixel_valid && pixel_ready
        |-> ##[1:5] dac_valid)
        else $error("pixel word late");
    AST_RDY_RST: assert property ($fell(reset) |-> !pixel_ready)
        else $error("ready too early after reset");
    AST_RDY_UP: assert property ($fell(reset) |-> ##[1:2] pixel_ready)
        else $error("ready late after reset");
    // Main scenarios reached
    COV_STALL: cover property (dac_valid && !dac_ready);
    COV_REFUSE: cover property (pixel_valid && !pixel_ready);
    COV_BLANK: cover property (dac_valid && !dac_blank_n);
endmodule // pmf_formatter_checker

bind pmf_formatter pmf_formatter_checker chk (.*);

/* File: pmf_pal_model.sv */
// Palette and overlay lookup model with one cycle latency
`timescale 1ns/10ps
module pmf_pal_model (
    // Clock
    input wire logic        sys_clk,
    // Lookup addresses
    input wire logic [7:0]  addr_red,
    input wire logic [7:0]  addr_green,
    input wire logic [7:0]  addr_blue,
    input wire logic [3:0]  ovl_addr,
    // Lookup data
    output pmf_pkg::pmf_dac_t pal_data,
    output pmf_pkg::pmf_dac_t ovl_data
);
    // ----
    // Contents derived from address
    // ----
    always_ff @(posedge sys_clk)
    begin
        pal_data <= {~addr_red, ~addr_green, ~addr_blue, 2'h3};
        ovl_data <= {4'ha, ovl_addr, 4'hb, ovl_addr, 4'hc, ovl_addr, 2'h3};
    end
endmodule // pmf_pal_model

/* File: pixel_mode_formatter_test.sv */
// Self-checking bench for the pixel mode formatter
`timescale 1ns/10ps
module pixel_mode_formatter_test;
    logic sys_clk = 0, reset = 1, pixel_valid = 0, dac_ready = 1;
    logic host_sel = 0, host_wr = 0, host_rd = 0, hi = 0, lo = 0;
    logic sync_n = 1, blank_n = 1, dac_valid, pixel_ready, host_read_valid;
    logic [7:0] red = 0, green = 0, blue = 0, host_data_bus = 0;
    logic [7:0] ar, ag, ab, host_read_data, dr, dg, db;
    logic [3:0] overlay_select = 0, oa;
    logic       ds, dk, su;
    pmf_pkg::pmf_dac_t pd, od;
    int error_cnt = 0, comparisons = 0;
    always #5 sys_clk = ~sys_clk;
    pmf_pal_model pal (.sys_clk(sys_clk), .addr_red(ar), .addr_green(ag),
        .addr_blue(ab), .ovl_addr(oa), .pal_data(pd), .ovl_data(od));
    pmf_formatter uut (.sys_clk(sys_clk), .reset(reset),
        .pixel_valid(pixel_valid), .pixel_ready(pixel_ready),
        .red_pixel_bus(red), .green_pixel_bus(green), .blue_pixel_bus(blue),
        .overlay_select(overlay_select), .pixel_mode_pin_hi(hi),
        .pixel_mode_pin_lo(lo), .sync_n(sync_n), .blank_n(blank_n),
        .host_data_bus(host_data_bus), .host_sel(host_sel),
        .host_wr(host_wr), .host_rd(host_rd),
        .host_read_data(host_read_data), .host_read_valid(host_read_valid),
        .pal_addr_red(ar), .pal_addr_green(ag), .pal_addr_blue(ab),
        .pal_data(pd), .ovl_addr(oa), .ovl_data(od), .dac_valid(dac_valid),
        .dac_ready(dac_ready), .dac_red(dr), .dac_green(dg), .dac_blue(db),
        .dac_sync_n(ds), .dac_blank_n(dk), .dac_setup_en(su));
    // ----
    // Shared tasks
    // ----
    task automatic chk(input string n, input logic [25:0] e, s);
        comparisons++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic hw(input logic s, input logic [7:0] d);
        @(posedge sys_clk) {host_sel, host_data_bus, host_wr} <= {s, d, 1'b1};
        @(posedge sys_clk) host_wr <= 0;
    endtask
    task automatic hr(input logic s, input logic [7:0] e);
        {host_sel, host_rd} <= {s, 1'b1};
        @(posedge sys_clk) host_rd <= 0;
        #1 chk("host read", {17'h1, e}, {host_read_valid, host_read_data});
    endtask
    task automatic px(input logic [3:0] o, input logic [1:0] m,
        input logic [23:0] d, input logic [1:0] sb, input logic [23:0] e);
        int n;
        @(posedge sys_clk) pixel_valid <= 1;
        {overlay_select, hi, lo, red, green, blue, sync_n, blank_n} <=
            {o, m, d, sb};
        do @(posedge sys_clk); while (pixel_ready !== 1);
        pixel_valid <= 0;
        for (n = 0; n < 20 && dac_valid !== 1; n++) @(negedge sys_clk);
        chk("dac word", {e, sb}, {dr, dg, db, ds, dk});
        @(posedge sys_clk);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic s_mask;
        hr(0, 8'hff);
        hw(0, 8'h0f);
        hr(0, 8'h0f);
        px(0, 0, 24'habcd12, 3, 24'hf4f2fd);
        px(0, 2, 24'habcd12, 3, 24'hf4f4f4);
        hw(0, 8'hff);
    endtask
    task automatic s_bypass;
        px(0, 1, 24'habcd12, 3, 24'habcd12);
        px(0, 3, 24'hb60000, 3, 24'ha0a080);
        hw(1, 8'h40);
        px(0, 3, 24'h00b600, 3, 24'ha0a080);
        hw(1, 8'hc0);
        px(0, 3, 24'h5a7300, 3, 24'hb09898);
        px(0, 2, 24'h5a7300, 3, 24'h090c0c);
    endtask
    task automatic s_overlay;
        px(5, 1, 24'h123456, 3, 24'ha5b5c5);
        px(15, 2, 24'h5a7300, 3, 24'hafbfcf);
        px(5, 1, 24'h123456, 0, 24'h000000);
        chk("setup", 0, su);
        hw(1, 8'he0);
        hr(1, 8'he0);
        chk("setup", 1, su);
    endtask
    task automatic s_fill;
        int n = 0, m = 0;
        @(posedge sys_clk) {dac_ready, pixel_valid, overlay_select} <= 6'h10;
        repeat (30) @(posedge sys_clk) if (pixel_ready === 1) n++;
        pixel_valid <= 0;
        dac_ready <= 1;
        chk("refused", 0, pixel_ready);
        repeat (40) @(posedge sys_clk) if (dac_valid === 1) m++;
        chk("drained", n, m);
    endtask
    task automatic stop_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset <= 0;
        repeat (2) @(posedge sys_clk);
        s_mask;
        s_bypass;
        s_overlay;
        s_fill;
        stop_test;
    end
    // Watchdog
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        stop_test;
    end
endmodule // pixel_mode_formatter_test
